//--- dplc_checker.sv
// Concurrent checks on the ports of the loop-control block
module dplc_checker import dplc_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic [1:0] o_s_axi_bresp,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_pd_step,
  input wire logic [23:0] o_integer_feedback_value,
  input wire logic o_phase_lock,
  input wire logic o_freq_lock,
  input wire logic [2:0] o_loop_state,
  input wire logic o_active_profile
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // ************************************************************
  // Bus handshakes
  // ************************************************************
  sequence s_wr_taken;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  sequence s_rd_taken;
    i_s_axi_arvalid && o_s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |=> !o_s_axi_bvalid ##1
    o_s_axi_bvalid) else $error("write answer not two cycles after");
  a_read_answer: assert property (s_rd_taken |=> o_s_axi_rvalid)
    else $error("read answer not one cycle after");
  a_bresp_stands: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
    o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("bresp dropped");
  a_rdata_stands: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
    o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("rdata dropped");
  a_busy_refuse: assert property (o_s_axi_bvalid |-> !o_s_axi_awready &&
    !o_s_axi_wready) else $error("write taken while answer pending");
  // ************************************************************
  // Loop side
  // ************************************************************
  a_lock_on_step: assert property (!$past(i_pd_step) |->
    $stable(o_phase_lock) && $stable(o_freq_lock))
    else $error("lock moved without a detector step");
  a_hold_unlock: assert property (o_loop_state inside
    {ST_FREERUN, ST_HOLDOVER} |-> !o_phase_lock)
    else $error("phase lock shown in free run or holdover");
  a_switch_freeze: assert property (o_loop_state == ST_SWITCH |->
    $stable(o_phase_lock) && $stable(o_freq_lock))
    else $error("lock changed during switchover");
  a_div_transfer: assert property (
    $changed(o_integer_feedback_value) |->
    $rose(o_s_axi_bvalid) && !o_active_profile)
    else $error("divider changed without transfer");
endmodule

bind dplc_top dplc_checker u_chk (.*);

//--- dplc_lock_tub.sv
// Leaky-bucket lock detector used for phase and frequency lock
module dplc_lock_tub #(
  parameter int ERR_W = 24,
  parameter int THR_W = 16
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_step,
  input wire logic signed [ERR_W-1:0] i_err,
  input wire logic [THR_W-1:0] i_thr,
  input wire logic [7:0] i_fill,
  input wire logic [7:0] i_drain,
  input wire logic i_force_unlock,
  input wire logic i_freeze,
  output logic o_locked
);
  import dplc_pkg::*;

  typedef struct packed {
    logic signed [12:0] level;
    logic locked;
  } dplc_tub_s;

  dplc_tub_s r;
  dplc_tub_s next_r;
  logic [ERR_W-1:0] mag;
  logic signed [13:0] wide;

  always_comb begin
    next_r = r;
    mag = i_err[ERR_W-1] ? ERR_W'(-i_err) : ERR_W'(i_err);
    wide = {r.level[12], r.level};
    if (i_force_unlock) begin
      next_r.level = LVL_EMPTY;
      next_r.locked = 1'b0;
    end else if (i_freeze) begin
      next_r = r;
    end else if (i_step) begin
      // Exactly one bucket per detector cycle
      if (mag <= ERR_W'(i_thr)) begin
        wide = wide + 14'(i_fill);
        next_r.level = (wide > 14'(LVL_FULL)) ? LVL_FULL : 13'(wide);
      end else begin
        wide = wide - 14'(i_drain);
        next_r.level = (wide < 14'(LVL_EMPTY)) ? LVL_EMPTY : 13'(wide);
      end
      if (next_r.level > LVL_HIGH) begin
        next_r.locked = 1'b1;
      end else if (next_r.level < LVL_LOW) begin
        next_r.locked = 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      r <= '{level: LVL_EMPTY, locked: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign o_locked = r.locked;
endmodule

//--- dplc_pkg.sv
// Shared constants and types of the loop-control block
package dplc_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [13:0] IDX_XFER = 14'h0005;
  localparam logic [13:0] IDX_INT = 14'h0715;
  localparam logic [13:0] IDX_NUM = 14'h0718;
  localparam logic [13:0] IDX_MOD = 14'h071b;
  localparam logic [13:0] IDX_MODE = 14'h0a01;
  localparam logic [13:0] IDX_PTHR_A = 14'h0720;
  localparam logic [13:0] IDX_FTHR_A = 14'h0721;
  localparam logic [13:0] IDX_RATE_A = 14'h0722;
  localparam logic [13:0] IDX_PTHR_B = 14'h0760;
  localparam logic [13:0] IDX_FTHR_B = 14'h0761;
  localparam logic [13:0] IDX_RATE_B = 14'h0762;
  localparam logic [13:0] IDX_CLAMP_LO = 14'h0730;
  localparam logic [13:0] IDX_CLAMP_HI = 14'h0731;
  localparam logic [13:0] IDX_FREERUN = 14'h0732;
  localparam logic [13:0] IDX_AVG = 14'h0733;
  localparam logic [13:0] IDX_STATUS = 14'h0734;

  // ****************************************************************
  // Fields, commands and reset values
  // ****************************************************************
  localparam logic [7:0] XFER_GO = 8'h01;
  localparam int MODE_FREERUN_BIT = 5;
  localparam int MODE_HOLD_BIT = 6;
  localparam int RATE_PFILL_LSB = 0;
  localparam int RATE_PDRAIN_LSB = 8;
  localparam int RATE_FFILL_LSB = 16;
  localparam int RATE_FDRAIN_LSB = 24;
  localparam int TW_W = 30;
  localparam int PERR_W = 24;
  localparam int FDIF_W = 25;
  localparam logic [23:0] INT_RST = 24'h000000;
  localparam logic [23:0] NUM_RST = 24'h000000;
  localparam logic [23:0] MOD_RST = 24'h000001;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [15:0] PTHR_RST = 16'h0000;
  localparam logic [23:0] FTHR_RST = 24'h000000;
  localparam logic [31:0] RATE_RST = 32'h01010101;
  localparam logic [29:0] CLAMP_LO_RST = 30'h00000000;
  localparam logic [29:0] CLAMP_HI_RST = 30'h3fffffff;
  localparam logic [29:0] FREERUN_RST = 30'h00000000;
  localparam logic [3:0] AVG_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ****************************************************************
  // Lock level limits
  // ****************************************************************
  localparam logic signed [12:0] LVL_EMPTY = -13'sd2048;
  localparam logic signed [12:0] LVL_FULL = 13'sd2048;
  localparam logic signed [12:0] LVL_LOW = -13'sd1024;
  localparam logic signed [12:0] LVL_HIGH = 13'sd1024;

  typedef enum logic [2:0] {
    ST_FREERUN = 3'b000,
    ST_CLOSED = 3'b001,
    ST_HOLDOVER = 3'b010,
    ST_SWITCH = 3'b011,
    ST_RETUNE = 3'b100,
    ST_RECOVER = 3'b101
  } dplc_state_e;

endpackage

//--- dplc_top.sv
// Loop control: divider transfer in profile 0 only, lock detectors, clamp, history, states
module dplc_top (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic [15:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [15:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_pd_step,
  input wire logic signed [dplc_pkg::PERR_W-1:0] i_phase_err,
  input wire logic signed [dplc_pkg::FDIF_W-1:0] i_period_diff,
  input wire logic [dplc_pkg::TW_W-1:0] i_filter_word,
  input wire logic i_ref_valid,
  input wire logic i_ref_sel,
  output logic [dplc_pkg::TW_W-1:0] o_tuning_word,
  output logic [23:0] o_integer_feedback_value,
  output logic [23:0] o_fraction_numerator,
  output logic [23:0] o_fraction_modulus,
  output logic o_phase_lock,
  output logic o_freq_lock,
  output logic [2:0] o_loop_state,
  output logic o_active_profile
);
  import dplc_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic aw_hold;
    logic [13:0] aw_idx;
    logic w_hold;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [23:0] int_sh;
    logic [23:0] num_sh;
    logic [23:0] mod_sh;
    logic [23:0] int_act;
    logic [23:0] num_act;
    logic [23:0] mod_act;
    logic [7:0] mode;
    logic [1:0][15:0] pthr;
    logic [1:0][23:0] fthr;
    logic [1:0][31:0] rates;
    logic [29:0] clamp_lo;
    logic [29:0] clamp_hi;
    logic [29:0] freerun;
    logic [29:0] tw_out;
    logic [29:0] avg;
    logic [3:0] avg_shift;
    logic [44:0] avg_sum;
    logic [15:0] avg_cnt;
    logic hist_valid;
    dplc_state_e st;
    logic act_prof;
    logic retune_pend;
  } dplc_regs_s;

  dplc_regs_s r;
  dplc_regs_s next_r;
  logic phase_locked;
  logic freq_locked;
  logic [29:0] clamped;
  logic [31:0] merged;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic wr_ok;
  logic xfer;
  logic [44:0] sum_now;
  logic [15:0] avg_len;
  logic force_fr;
  logic force_ho;
  logic lock_clear;
  logic lock_hold;

  // Judged on the coming state so locks move at the same step edge
  assign lock_clear = next_r.st == ST_FREERUN || next_r.st == ST_HOLDOVER;
  assign lock_hold = r.st == ST_SWITCH || r.st == ST_RETUNE ||
                     next_r.st == ST_SWITCH || next_r.st == ST_RETUNE;

  // ****************************************************************
  // Lock detectors
  // ****************************************************************
  dplc_lock_tub #(.ERR_W(PERR_W), .THR_W(16)) u_phase_tub (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_step(i_pd_step),
    .i_err(i_phase_err),
    .i_thr(r.pthr[r.act_prof]),
    .i_fill(r.rates[r.act_prof][RATE_PFILL_LSB+:8]),
    .i_drain(r.rates[r.act_prof][RATE_PDRAIN_LSB+:8]),
    .i_force_unlock(lock_clear),
    .i_freeze(lock_hold),
    .o_locked(phase_locked)
  );

  // Same free-run/holdover drain so frequency lock never reads stale
  dplc_lock_tub #(.ERR_W(FDIF_W), .THR_W(24)) u_freq_tub (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_step(i_pd_step),
    .i_err(i_period_diff),
    .i_thr(r.fthr[r.act_prof]),
    .i_fill(r.rates[r.act_prof][RATE_FFILL_LSB+:8]),
    .i_drain(r.rates[r.act_prof][RATE_FDRAIN_LSB+:8]),
    .i_force_unlock(lock_clear),
    .i_freeze(lock_hold),
    .o_locked(freq_locked)
  );

  // ****************************************************************
  // Register read mux
  // ****************************************************************
  always_comb begin
    rd_ok = 1'b1;
    rd_mux = 32'h00000000;
    unique case (i_s_axi_araddr[15:2])
      IDX_XFER: rd_mux = 32'h00000000;
      IDX_INT: rd_mux = {8'h00, r.int_sh};
      IDX_NUM: rd_mux = {8'h00, r.num_sh};
      IDX_MOD: rd_mux = {8'h00, r.mod_sh};
      IDX_MODE: rd_mux = {24'h000000, r.mode};
      IDX_PTHR_A: rd_mux = {16'h0000, r.pthr[0]};
      IDX_FTHR_A: rd_mux = {8'h00, r.fthr[0]};
      IDX_RATE_A: rd_mux = r.rates[0];
      IDX_PTHR_B: rd_mux = {16'h0000, r.pthr[1]};
      IDX_FTHR_B: rd_mux = {8'h00, r.fthr[1]};
      IDX_RATE_B: rd_mux = r.rates[1];
      IDX_CLAMP_LO: rd_mux = {2'b00, r.clamp_lo};
      IDX_CLAMP_HI: rd_mux = {2'b00, r.clamp_hi};
      IDX_FREERUN: rd_mux = {2'b00, r.freerun};
      IDX_AVG: rd_mux = {28'h0000000, r.avg_shift};
      IDX_STATUS: rd_mux = {23'h000000, r.retune_pend, r.hist_valid,
                            r.act_prof, phase_locked, freq_locked, r.st};
      default: rd_ok = 1'b0;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_r = r;
    xfer = 1'b0;
    wr_ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      merged[8*i+:8] = r.wstrb[i] ? r.wdata[8*i+:8] : 8'h00;
    end
    clamped = i_filter_word;
    if (i_filter_word < r.clamp_lo) begin
      clamped = r.clamp_lo;
    end else if (i_filter_word > r.clamp_hi) begin
      clamped = r.clamp_hi;
    end
    sum_now = r.avg_sum + 45'(clamped);
    avg_len = 16'((32'd1 << r.avg_shift) - 32'd1);
    force_fr = r.mode[MODE_FREERUN_BIT];
    force_ho = r.mode[MODE_HOLD_BIT];

    // Bus: address and data accepted in either order
    if (i_s_axi_awvalid && o_s_axi_awready) begin
      next_r.aw_hold = 1'b1;
      next_r.aw_idx = i_s_axi_awaddr[15:2];
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      next_r.w_hold = 1'b1;
      next_r.wdata = i_s_axi_wdata;
      next_r.wstrb = i_s_axi_wstrb;
    end
    if (r.bvalid && i_s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.aw_hold && r.w_hold) begin
      next_r.aw_hold = 1'b0;
      next_r.w_hold = 1'b0;
      next_r.bvalid = 1'b1;
      // Partial strobes leave unstrobed bytes of a register unchanged
      for (int i = 0; i < 4; i++) begin
        if (!r.wstrb[i]) begin
          merged[8*i+:8] = 8'h00;
        end
      end
      unique case (r.aw_idx)
        IDX_XFER: xfer = r.wstrb[0] && r.wdata[7:0] == XFER_GO;
        IDX_INT: next_r.int_sh = merge24(r.int_sh);
        IDX_NUM: next_r.num_sh = merge24(r.num_sh);
        IDX_MOD: next_r.mod_sh = merge24(r.mod_sh);
        IDX_MODE: next_r.mode = r.wstrb[0] ? r.wdata[7:0] : r.mode;
        IDX_PTHR_A: next_r.pthr[0] = 16'(merge32({16'h0000, r.pthr[0]}));
        IDX_FTHR_A: next_r.fthr[0] = merge24(r.fthr[0]);
        IDX_RATE_A: next_r.rates[0] = merge32(r.rates[0]);
        IDX_PTHR_B: next_r.pthr[1] = 16'(merge32({16'h0000, r.pthr[1]}));
        IDX_FTHR_B: next_r.fthr[1] = merge24(r.fthr[1]);
        IDX_RATE_B: next_r.rates[1] = merge32(r.rates[1]);
        IDX_CLAMP_LO: next_r.clamp_lo = 30'(merge32({2'b00, r.clamp_lo}));
        IDX_CLAMP_HI: next_r.clamp_hi = 30'(merge32({2'b00, r.clamp_hi}));
        IDX_FREERUN: next_r.freerun = 30'(merge32({2'b00, r.freerun}));
        IDX_AVG: next_r.avg_shift = r.wstrb[0] ? r.wdata[3:0] : r.avg_shift;
        IDX_STATUS: wr_ok = 1'b0;
        default: wr_ok = 1'b0;
      endcase
      next_r.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (r.rvalid && i_s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (i_s_axi_arvalid && o_s_axi_arready) begin
      next_r.rvalid = 1'b1;
      next_r.rdata = rd_mux;
      next_r.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // Loop state machine, one step per detector cycle
    if (i_pd_step) begin
      unique case (r.st)
        ST_FREERUN: begin
          if (!force_fr) begin
            if (force_ho) begin
              next_r.st = ST_HOLDOVER;
            end else if (i_ref_valid) begin
              next_r.st = ST_RECOVER;
            end
          end
        end
        ST_CLOSED: begin
          if (force_fr) begin
            next_r.st = ST_FREERUN;
          end else if (force_ho || !i_ref_valid) begin
            next_r.st = ST_HOLDOVER;
          end else if (i_ref_sel != r.act_prof) begin
            next_r.st = ST_SWITCH;
          end else if (r.retune_pend) begin
            next_r.st = ST_RETUNE;
            next_r.retune_pend = 1'b0;
          end
        end
        ST_HOLDOVER: begin
          if (force_fr) begin
            next_r.st = ST_FREERUN;
          end else if (i_ref_valid && !force_ho) begin
            next_r.st = ST_RECOVER;
          end
        end
        ST_SWITCH: begin
          next_r.act_prof = i_ref_sel;
          next_r.st = ST_CLOSED;
        end
        ST_RETUNE: next_r.st = ST_CLOSED;
        ST_RECOVER: begin
          next_r.act_prof = i_ref_sel;
          next_r.st = ST_CLOSED;
        end
        default: next_r.st = ST_FREERUN;
      endcase

      unique case (next_r.st)
        ST_CLOSED, ST_RECOVER: next_r.tw_out = clamped;
        ST_FREERUN: next_r.tw_out = r.freerun;
        ST_HOLDOVER: begin
          // Without history, holding the last word is the best estimate
          if (r.st != ST_HOLDOVER && r.hist_valid) begin
            next_r.tw_out = r.avg;
          end
        end
        ST_SWITCH, ST_RETUNE: next_r.tw_out = r.tw_out;
        default: next_r.tw_out = r.tw_out;
      endcase

      // History only from a closed loop, so holdover never averages itself
      if (r.st == ST_CLOSED) begin
        if (r.avg_cnt == avg_len) begin
          next_r.avg = 30'(sum_now >> r.avg_shift);
          next_r.hist_valid = 1'b1;
          next_r.avg_sum = 45'h0;
          next_r.avg_cnt = 16'h0000;
        end else begin
          next_r.avg_sum = sum_now;
          next_r.avg_cnt = r.avg_cnt + 16'h0001;
        end
      end
    end

    // Transfer after the state step so a new request wins over the clear
    if (xfer && r.act_prof == 1'b0) begin
      next_r.int_act = r.int_sh;
      next_r.num_act = r.num_sh;
      next_r.mod_act = r.mod_sh;
      if (r.int_sh != r.int_act || r.mod_sh != r.mod_act) begin
        next_r.retune_pend = 1'b1;
      end
    end
  end

  function automatic logic [31:0] merge32(input logic [31:0] old);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (r.wstrb[i]) begin
        res[8*i+:8] = r.wdata[8*i+:8];
      end
    end
    return res;
  endfunction

  function automatic logic [23:0] merge24(input logic [23:0] old);
    logic [31:0] res;
    res = merge32({8'h00, old});
    return res[23:0];
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      r <= '0;
      r.mod_sh <= MOD_RST;
      r.mod_act <= MOD_RST;
      r.int_sh <= INT_RST;
      r.int_act <= INT_RST;
      r.num_sh <= NUM_RST;
      r.num_act <= NUM_RST;
      r.mode <= MODE_RST;
      r.pthr <= {PTHR_RST, PTHR_RST};
      r.fthr <= {FTHR_RST, FTHR_RST};
      r.rates <= {RATE_RST, RATE_RST};
      r.clamp_lo <= CLAMP_LO_RST;
      r.clamp_hi <= CLAMP_HI_RST;
      r.freerun <= FREERUN_RST;
      r.tw_out <= FREERUN_RST;
      r.avg_shift <= AVG_RST;
      r.st <= ST_FREERUN;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_s_axi_awready = !r.aw_hold && !r.bvalid;
  assign o_s_axi_wready = !r.w_hold && !r.bvalid;
  assign o_s_axi_bvalid = r.bvalid;
  assign o_s_axi_bresp = r.bresp;
  assign o_s_axi_arready = !r.rvalid;
  assign o_s_axi_rvalid = r.rvalid;
  assign o_s_axi_rdata = r.rdata;
  assign o_s_axi_rresp = r.rresp;
  assign o_tuning_word = r.tw_out;
  assign o_integer_feedback_value = r.int_act;
  assign o_fraction_numerator = r.num_act;
  assign o_fraction_modulus = r.mod_act;
  assign o_phase_lock = phase_locked;
  assign o_freq_lock = freq_locked;
  assign o_loop_state = r.st;
  assign o_active_profile = r.act_prof;
endmodule

//--- testbench.sv
// Self-checking bench for the loop-control block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dplc_pkg::*;
  logic i_mclk, i_nrst, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
  logic i_s_axi_arvalid, i_s_axi_rready, i_pd_step, i_ref_valid, i_ref_sel;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  logic o_s_axi_rvalid, o_phase_lock, o_freq_lock, o_active_profile;
  logic [15:0] i_s_axi_awaddr, i_s_axi_araddr;
  logic [31:0] i_s_axi_wdata, o_s_axi_rdata, t;
  logic [3:0] i_s_axi_wstrb;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
  logic signed [PERR_W-1:0] i_phase_err;
  logic signed [FDIF_W-1:0] i_period_diff;
  logic [TW_W-1:0] i_filter_word, o_tuning_word;
  logic [23:0] o_integer_feedback_value, o_fraction_numerator;
  logic [23:0] o_fraction_modulus;
  logic [2:0] o_loop_state;
  int errors = 0;
  int tests_run = 0;
  dplc_top dut (.*);
  always #50 i_mclk = ~i_mclk;
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [13:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    int n;
    tb = 0;
    n = 0;
    i_s_axi_awaddr <= {idx, 2'b00};
    i_s_axi_wdata <= d;
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= 3'b111;
    while (!tb && n < 50) begin
      @(negedge i_mclk);
      ta = i_s_axi_awvalid && o_s_axi_awready;
      tw = i_s_axi_wvalid && o_s_axi_wready;
      tb = o_s_axi_bvalid;
      r = o_s_axi_bresp;
      @(posedge i_mclk);
      if (ta) i_s_axi_awvalid <= 0;
      if (tw) i_s_axi_wvalid <= 0;
      n++;
    end
    i_s_axi_bready <= 0;
    chk("bresp", {30'h0, er}, {30'h0, r});
    @(posedge i_mclk);
  endtask
  task automatic rdc(input logic [13:0] idx, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tb;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    tb = 0;
    n = 0;
    i_s_axi_araddr <= {idx, 2'b00};
    {i_s_axi_arvalid, i_s_axi_rready} <= 2'b11;
    while (!tb && n < 50) begin
      @(negedge i_mclk);
      ta = i_s_axi_arvalid && o_s_axi_arready;
      tb = o_s_axi_rvalid;
      d = o_s_axi_rdata;
      r = o_s_axi_rresp;
      @(posedge i_mclk);
      if (ta) i_s_axi_arvalid <= 0;
      n++;
    end
    i_s_axi_rready <= 0;
    chk("rdata", ed, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
    @(posedge i_mclk);
  endtask
  // One detector cycle; outputs settle at the step edge itself, then two more edges pass
  task automatic step(input int e, input int n = 1);
    repeat (n) begin
      i_phase_err <= e[PERR_W-1:0];
      i_pd_step <= 1;
      @(posedge i_mclk);
      i_pd_step <= 0;
      repeat (2) @(posedge i_mclk);
    end
  endtask
  task automatic ws(input logic [2:0] s);
    int n;
    n = 0;
    while (o_loop_state !== s && n < 40) begin
      step(0);
      n++;
    end
    chk("state", {29'h0, s}, {29'h0, o_loop_state});
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs;
    chk("int", 0, o_integer_feedback_value);
    chk("mod", 1, o_fraction_modulus);
    chk("locks", 0, {o_phase_lock, o_freq_lock});
    wr(IDX_INT, 5, RESP_OKAY);
    wr(IDX_NUM, 7, RESP_OKAY);
    wr(IDX_MOD, 9, RESP_OKAY);
    rdc(IDX_INT, 5, RESP_OKAY);
    chk("int held", 0, o_integer_feedback_value);
    rdc(14'h0001, 0, RESP_SLVERR);
    wr(IDX_STATUS, 1, RESP_SLVERR);
    wr(IDX_RATE_A, 32'hffffffff, RESP_OKAY);
    wr(IDX_PTHR_A, 100, RESP_OKAY);
    wr(IDX_CLAMP_HI, 32'h800, RESP_OKAY);
  endtask
  task automatic t_transfer;
    wr(IDX_XFER, XFER_GO, RESP_OKAY);
    chk("int", 5, o_integer_feedback_value);
    chk("num", 7, o_fraction_numerator);
    chk("mod", 9, o_fraction_modulus);
    step(0);
    chk("retune", ST_RETUNE, o_loop_state);
    step(0);
    chk("back", ST_CLOSED, o_loop_state);
    wr(IDX_NUM, 8, RESP_OKAY);
    wr(IDX_XFER, XFER_GO, RESP_OKAY);
    step(0);
    chk("num only", ST_CLOSED, o_loop_state);
    chk("num", 8, o_fraction_numerator);
    i_filter_word <= 30'h1000;
    step(0);
    chk("clamp", 32'h800, o_tuning_word);
  endtask
  // Buckets of 255: 13 steps cross a mark from a saturated end
  task automatic t_lock;
    step(101, 17);
    step(-100, 12);
    chk("below mark", 0, o_phase_lock);
    step(-100);
    chk("lock", 1, o_phase_lock);
    chk("freq lock", 1, o_freq_lock);
    step(-100, 4);
    step(101, 12);
    chk("hold", 1, o_phase_lock);
    step(101);
    chk("unlock", 0, o_phase_lock);
    step(-100, 17);
  endtask
  task automatic t_switch;
    i_ref_sel <= 1;
    step(101);
    chk("switch", ST_SWITCH, o_loop_state);
    chk("frozen", 3, {o_phase_lock, o_freq_lock});
    step(101);
    chk("closed", ST_CLOSED, o_loop_state);
    chk("profile", 1, o_active_profile);
    wr(IDX_INT, 6, RESP_OKAY);
    wr(IDX_XFER, XFER_GO, RESP_OKAY);
    chk("no retune", 5, o_integer_feedback_value);
  endtask
  task automatic t_hold;
    wr(IDX_MODE, 32'h40, RESP_OKAY);
    step(0);
    chk("hold", ST_HOLDOVER, o_loop_state);
    chk("unlock", 0, o_phase_lock);
    t = o_tuning_word;
    i_filter_word <= 30'h2000;
    step(0, 3);
    chk("still", ST_HOLDOVER, o_loop_state);
    chk("word", t, o_tuning_word);
    wr(IDX_MODE, 0, RESP_OKAY);
    ws(ST_CLOSED);
    wr(IDX_FREERUN, 32'h123, RESP_OKAY);
    wr(IDX_MODE, 32'h20, RESP_OKAY);
    rdc(IDX_MODE, 32'h20, RESP_OKAY);
    step(0);
    chk("free", ST_FREERUN, o_loop_state);
    chk("fr word", 32'h123, o_tuning_word);
  endtask
  initial begin
    #1ms;
    errors++;
    conclude();
  end
  initial begin
    i_mclk = 0;
    i_nrst = 0;
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid} = '0;
    {i_s_axi_rready, i_pd_step, i_ref_valid, i_ref_sel} = '0;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = '0;
    i_s_axi_wstrb = 4'hf;
    {i_phase_err, i_period_diff, i_filter_word} = '0;
    repeat (5) @(posedge i_mclk);
    i_nrst <= 1;
    @(posedge i_mclk);
    t_regs();
    i_ref_valid <= 1;
    ws(ST_CLOSED);
    t_transfer();
    t_lock();
    t_switch();
    t_hold();
    conclude();
  end
endmodule
